// File: pkg/dilpc_pkg.sv
// constants, types and helpers for the interrupt and low-power controller
// Functional notes
// - fixed priority, reset 0000 highest, power-down 002C, timer 0028 lowest
// - pending requests ANDed with mask, highest unmasked one is chosen
// - power-down and reset are never blocked by mask bits
// - a mask write blocks all interrupts for one cycle
// - control reg selects nesting and edge/level for three pins
// - two level pins, one edge pin that software can force/clear
// - nesting lets higher priority preempt, otherwise strictly sequential
// - force/clear register is write-only, reads zero
// - status pushed on entry, popped on return, twelve shared levels
// - global enable/disable gates all servicing incl. power-down
// - global servicing is enabled after reset
// - second serial port reconfigured gives two irq pins and flag pins
// - wake with oscillator running resumes within 400 cycles
// - wake with oscillator stopped waits 4096 cycles
// - pin or force bit raises edge power-down irq, handler then sleeps
// - context bit picks resume or clean restart after dormant
// - reset ends the dormant state
// - acknowledge output shows the dormant state
// - idle stalls until an unmasked interrupt, then continues
// - divided idle slows processor clock by 16, 32, 64 or 128
// - serial, clock-out and timer ticks slow by the same divisor; here only proc_tick_o is divided
// - divided idle may delay interrupt response up to n cycles
package dilpc_pkg;

  localparam int NSRC = 11;
  localparam int AW   = 5;

  // =====================================================================
  // source indices in priority order
  localparam logic [3:0] SRC_PD  = 4'h0;
  localparam logic [3:0] SRC_DA  = 4'h1;
  localparam logic [3:0] SRC_L1  = 4'h2;
  localparam logic [3:0] SRC_L0  = 4'h3;
  localparam logic [3:0] SRC_S0T = 4'h4;
  localparam logic [3:0] SRC_S0R = 4'h5;
  localparam logic [3:0] SRC_E   = 4'h6;
  localparam logic [3:0] SRC_BXP = 4'h7;
  localparam logic [3:0] SRC_S1T = 4'h8;
  localparam logic [3:0] SRC_S1R = 4'h9;
  localparam logic [3:0] SRC_TMR = 4'hA;
  localparam logic [3:0] SRC_NONE = 4'hF;
  localparam logic [15:0] VEC_RST = 16'h0000;

  // =====================================================================
  // register map
  localparam logic [AW-1:0] OFS_MASK = 5'h00;
  localparam logic [AW-1:0] OFS_CTRL = 5'h04;
  localparam logic [AW-1:0] OFS_FCLR = 5'h08;
  localparam logic [AW-1:0] OFS_CMD  = 5'h0C;
  localparam logic [AW-1:0] OFS_STAT = 5'h10;
  localparam int CTL_NEST   = 0;
  localparam int CTL_SENS_A = 1;
  localparam int CTL_SENS_0 = 2;
  localparam int CTL_SENS_1 = 3;
  localparam int CTL_SP1IRQ = 4;
  localparam int CTL_POWERUP_CONTEXT_RESET_BIT   = 5;
  localparam int CTL_FLAGO  = 6;
  localparam int CTL_OSCOFF = 7;
  localparam int CMD_ENA  = 0;
  localparam int CMD_DIS  = 1;
  localparam int CMD_IDLE = 2;
  localparam int CMD_DIV  = 3;
  localparam int CMD_SLOW = 5;
  localparam int CMD_PDN  = 6;
  localparam int FC_CLR = 16;
  localparam int ST_GEN = 16;
  localparam int ST_PM  = 17;
  localparam int ST_DEP = 20;
  localparam int ST_OVF = 24;
  localparam int ST_FLG = 25;
  localparam int ST_REQ = 26;
  localparam logic [10:0] MASK_RST = 11'h000;
  localparam logic [7:0]  CTRL_RST = 8'h00;

  // =====================================================================
  // timing, in input clock cycles
  localparam int WAKE_FAST_CYC = 400;
  localparam int WAKE_OSC_CYC  = 4096;
  localparam int DIV_MIN       = 16;

  typedef enum logic [1:0] {PM_RUN, PM_IDLE, PM_DORM, PM_WAKE} dilpc_pm_t;

  typedef struct packed {
    logic dedicated_irq_pin_a_n;
    logic level_irq_pin_0_n;
    logic level_irq_pin_1_n;
    logic edge_irq_pin_n;
    logic shared_port_irq_0_n;
    logic shared_port_irq_1_n;
    logic power_down_request_pin_n;
    logic flag_in;
  } dilpc_pins_t;

  typedef struct packed {
    logic sp0_tx;
    logic sp0_rx;
    logic sp1_tx;
    logic sp1_rx;
    logic bxp;
    logic tmr;
  } dilpc_periph_t;

  typedef struct packed {
    logic [AW-1:0] address;
    logic          read;
    logic          write;
    logic [31:0]   writedata;
    logic [3:0]    byteenable;
  } dilpc_av_req_t;

  function automatic logic [15:0] dilpc_vec(input logic [3:0] i);
    case (i)
      SRC_PD:  return 16'h002C;
      SRC_DA:  return 16'h0004;
      SRC_L1:  return 16'h0008;
      SRC_L0:  return 16'h000C;
      SRC_S0T: return 16'h0010;
      SRC_S0R: return 16'h0014;
      SRC_E:   return 16'h0018;
      SRC_BXP: return 16'h001C;
      SRC_S1T: return 16'h0020;
      SRC_S1R: return 16'h0024;
      SRC_TMR: return 16'h0028;
      default: return VEC_RST;
    endcase
  endfunction

  // lowest set index, i.e. highest priority
  function automatic logic [3:0] dilpc_first(input logic [NSRC-1:0] v);
    logic [3:0] f;
    f = SRC_NONE;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        f = 4'(i);
      end
    end
    return f;
  endfunction

  function automatic logic [NSRC-1:0] dilpc_hot(input logic [3:0] i);
    return (i == SRC_NONE) ? '0 : NSRC'(1) << i;
  endfunction

endpackage

// File: hw/dilpc_core.sv
// interrupt controller with idle, divided idle and power-down control
`timescale 1ns/10ps
module dilpc_core #(
  parameter int unsigned STK_DEPTH = 12,
  parameter int unsigned STAT_W    = 16,
  parameter int unsigned WAKE_OSC  = dilpc_pkg::WAKE_OSC_CYC
) (
  input  wire logic                    ref_clk_i,
  input  wire logic                    reset_n_i,
  input  wire dilpc_pkg::dilpc_av_req_t av_i,
  output logic [31:0]                  av_readdata_o,
  output logic                         av_waitrequest_o,
  input  wire dilpc_pkg::dilpc_pins_t  pins_i,
  input  wire dilpc_pkg::dilpc_periph_t periph_i,
  input  wire logic                    int_ack_i,
  input  wire logic                    int_rti_i,
  input  wire logic                    stk_push_i,
  input  wire logic                    stk_pop_i,
  input  wire logic [STAT_W-1:0]       stat_i,
  output logic [STAT_W-1:0]            stat_o,
  output logic                         irq_req_o,
  output logic [15:0]                  vector_o,
  output logic                         pd_ack_o,
  output logic                         core_run_o,
  output logic                         core_restart_o,
  output logic                         proc_tick_o,
  output logic                         flag_out_o
);
  import dilpc_pkg::*;

  if (STK_DEPTH < 1 || STK_DEPTH > 15) begin : g_chk_stk
    $error("stack depth must be 1 to 15");
  end
  if (WAKE_OSC < WAKE_FAST_CYC || WAKE_OSC > 8191) begin : g_chk_wake
    $error("oscillator wake count out of range");
  end

  localparam logic [12:0] WK_FAST = 13'(WAKE_FAST_CYC - 1);
  localparam logic [12:0] WK_OSC  = 13'(WAKE_OSC - 1);
  localparam logic [3:0]  STK_TOP = 4'(STK_DEPTH);
  localparam int          WAKE_LIM = WAKE_FAST_CYC;

  typedef struct packed {
    logic [NSRC-1:0]                  mask;
    logic [7:0]                       ctrl;
    logic [NSRC-1:0]                  epend;
    logic [NSRC-1:0]                  prev;
    logic [NSRC-1:0]                  isr;
    logic                             gen;
    logic                             blk;
    dilpc_pm_t                        pm;
    logic                             slow;
    logic [1:0]                       dsel;
    logic [6:0]                       dcnt;
    logic [12:0]                      wcnt;
    logic [3:0]                       depth;
    logic [STK_DEPTH-1:0][STAT_W-1:0] stk;
    logic                             ovf;
    logic [3:0]                       cur;
    logic                             req;
    logic [15:0]                      vec;
    logic [STAT_W-1:0]                sout;
    logic                             pdack;
    logic                             run;
    logic                             rst;
    logic                             tick;
    logic [31:0]                      rdata;
    logic                             waitreq;
  } dilpc_state_t;

  dilpc_state_t s_q;
  dilpc_state_t s_d;

  logic [NSRC-1:0] raw;
  logic [NSRC-1:0] emode;
  logic [NSRC-1:0] pend;
  logic [NSRC-1:0] elig;
  logic [NSRC-1:0] force_v;
  logic [NSRC-1:0] clr_v;
  logic [NSRC-1:0] edge_v;
  logic [3:0]      cand;
  logic [3:0]      top;
  logic            can_go;
  logic            wr_acc;
  logic            mask_wr;
  logic [31:0]     bemask;
  logic [6:0]      dmax;

  // =====================================================================
  // request sources
  always_comb begin
    raw = '0;
    raw[SRC_PD]  = ~pins_i.power_down_request_pin_n;
    raw[SRC_DA]  = ~pins_i.dedicated_irq_pin_a_n;
    raw[SRC_L1]  = ~pins_i.level_irq_pin_1_n;
    raw[SRC_L0]  = ~pins_i.level_irq_pin_0_n;
    raw[SRC_S0T] = periph_i.sp0_tx;
    raw[SRC_S0R] = periph_i.sp0_rx;
    raw[SRC_E]   = ~pins_i.edge_irq_pin_n;
    raw[SRC_BXP] = periph_i.bxp;
    raw[SRC_TMR] = periph_i.tmr;
    emode = '1;
    emode[SRC_L1] = 1'b0;
    emode[SRC_L0] = 1'b0;
    emode[SRC_DA] = s_q.ctrl[CTL_SENS_A];
    if (s_q.ctrl[CTL_SP1IRQ]) begin
      raw[SRC_S1T]   = ~pins_i.shared_port_irq_1_n;
      raw[SRC_S1R]   = ~pins_i.shared_port_irq_0_n;
      emode[SRC_S1T] = s_q.ctrl[CTL_SENS_1];
      emode[SRC_S1R] = s_q.ctrl[CTL_SENS_0];
    end else begin
      raw[SRC_S1T] = periph_i.sp1_tx;
      raw[SRC_S1R] = periph_i.sp1_rx;
    end
  end

  // =====================================================================
  // bus decode
  assign wr_acc  = av_i.write & ~s_q.waitreq;
  assign mask_wr = wr_acc & (av_i.address == OFS_MASK);
  assign force_v = (wr_acc && av_i.address == OFS_FCLR) ?
                   av_i.writedata[NSRC-1:0] : '0;
  assign clr_v   = (wr_acc && av_i.address == OFS_FCLR) ?
                   av_i.writedata[FC_CLR +: NSRC] : '0;
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      bemask[8*b +: 8] = {8{av_i.byteenable[b]}};
    end
  end

  // =====================================================================
  // prioritisation
  assign pend = s_q.epend | (raw & ~emode);
  assign edge_v = raw & ~s_q.prev & emode;
  assign elig = pend & (s_q.mask | dilpc_hot(SRC_PD));
  assign cand = dilpc_first(elig);
  assign top  = dilpc_first(s_q.isr);
  assign dmax = 7'((DIV_MIN << s_q.dsel) - 1);

  always_comb begin
    can_go = s_q.gen & ~s_q.blk & (cand != SRC_NONE);
    if (s_q.pm != PM_RUN && s_q.pm != PM_IDLE) begin
      can_go = 1'b0;
    end
    // off-tick cycles may only hold a request that is already raised
    if (s_q.pm == PM_IDLE && !s_q.tick && !s_q.req) begin
      can_go = 1'b0;
    end
    if (s_q.isr != '0 && !(s_q.ctrl[CTL_NEST] && cand < top)) begin
      can_go = 1'b0;
    end
  end

  // =====================================================================
  // next state
  always_comb begin
    s_d         = s_q;
    s_d.prev    = raw;
    s_d.blk     = mask_wr;
    s_d.rst     = 1'b0;
    s_d.waitreq = ~((av_i.read | av_i.write) & s_q.waitreq);
    s_d.epend   = (s_q.epend & ~clr_v) | force_v |
                  edge_v;
    s_d.req     = can_go;
    s_d.cur     = cand;
    s_d.vec     = dilpc_vec(cand);
    // read data, loaded while the request waits
    if ((av_i.read | av_i.write) & s_q.waitreq) begin
      s_d.rdata = '0;
      case (av_i.address)
        OFS_MASK: s_d.rdata[NSRC-1:0] = s_q.mask & ~dilpc_hot(SRC_PD);
        OFS_CTRL: s_d.rdata[7:0] = s_q.ctrl;
        OFS_STAT: begin
          s_d.rdata[NSRC-1:0]  = pend;
          s_d.rdata[ST_GEN]    = s_q.gen;
          s_d.rdata[ST_PM +: 2] = s_q.pm;
          s_d.rdata[ST_DEP +: 4] = s_q.depth;
          s_d.rdata[ST_OVF]    = s_q.ovf;
          s_d.rdata[ST_FLG]    = pins_i.flag_in;
          s_d.rdata[ST_REQ]    = s_q.req;
        end
        default: s_d.rdata = '0;
      endcase
    end
    // register writes
    if (mask_wr) begin
      s_d.mask = NSRC'((av_i.writedata & bemask) | (32'(s_q.mask) & ~bemask));
    end
    if (wr_acc && av_i.address == OFS_CTRL && av_i.byteenable[0]) begin
      s_d.ctrl = av_i.writedata[7:0];
    end
    if (wr_acc && av_i.address == OFS_CMD && av_i.byteenable[0]) begin
      if (av_i.writedata[CMD_ENA]) begin
        s_d.gen = 1'b1;
      end
      if (av_i.writedata[CMD_DIS]) begin
        s_d.gen = 1'b0;
      end
      if (av_i.writedata[CMD_IDLE] && s_q.pm == PM_RUN) begin
        s_d.pm   = PM_IDLE;
        s_d.slow = av_i.writedata[CMD_SLOW];
        s_d.dsel = av_i.writedata[CMD_DIV +: 2];
        s_d.dcnt = '0;
      end
      if (av_i.writedata[CMD_PDN] && s_q.pm == PM_RUN) begin
        s_d.pm    = PM_DORM;
        s_d.pdack = 1'b1;
        s_d.run   = 1'b0;
        s_d.req   = 1'b0;
      end
    end
    // divided processor tick
    s_d.tick = 1'b1;
    if (s_d.pm == PM_IDLE && s_d.slow) begin
      s_d.tick = (s_q.dcnt == '0);
      s_d.dcnt = (s_q.dcnt == '0) ? dmax : s_q.dcnt - 7'h01;
    end
    if (s_d.pm == PM_DORM || s_d.pm == PM_WAKE) begin
      s_d.tick = 1'b0;
    end
    // interrupt taken by the core
    if (int_ack_i && s_q.req) begin
      s_d.isr   = s_q.isr | dilpc_hot(s_q.cur);
      s_d.epend = ((s_q.epend & ~clr_v) & ~dilpc_hot(s_q.cur)) |
                  force_v | edge_v;
      s_d.req   = 1'b0;
      if (s_q.pm == PM_IDLE) begin
        s_d.pm   = PM_RUN;
        s_d.slow = 1'b0;
        s_d.tick = 1'b1;
      end
    end
    // shared status stack
    if (int_ack_i | stk_push_i) begin
      if (s_q.depth == STK_TOP) begin
        s_d.ovf = 1'b1;
      end else begin
        s_d.stk[s_q.depth] = stat_i;
        s_d.depth = s_q.depth + 4'h1;
      end
    end else if (int_rti_i | stk_pop_i) begin
      if (s_q.depth != '0) begin
        s_d.sout  = s_q.stk[s_q.depth - 4'h1];
        s_d.depth = s_q.depth - 4'h1;
      end
    end
    if (int_rti_i) begin
      s_d.isr = s_d.isr & ~dilpc_hot(top);
    end
    // dormant and wake
    case (s_q.pm)
      PM_DORM: begin
        s_d.req = 1'b0;
        if (raw[SRC_PD] && !s_q.prev[SRC_PD]) begin
          s_d.pm    = PM_WAKE;
          s_d.pdack = 1'b0;
          s_d.wcnt  = s_q.ctrl[CTL_OSCOFF] ? WK_OSC :
                      WK_FAST;
        end
      end
      PM_WAKE: begin
        s_d.req = 1'b0;
        if (s_q.wcnt == '0) begin
          s_d.pm  = PM_RUN;
          s_d.run = 1'b1;
          if (s_q.ctrl[CTL_POWERUP_CONTEXT_RESET_BIT]) begin
            s_d.rst   = 1'b1;
            s_d.isr   = '0;
            s_d.epend = '0;
            s_d.depth = '0;
            s_d.vec   = VEC_RST;
          end
        end else begin
          s_d.wcnt = s_q.wcnt - 13'h0001;
        end
      end
      default: begin
        if (s_q.pm == PM_IDLE && !(int_ack_i && s_q.req)) begin
          s_d.run = 1'b0;
        end else if (s_d.pm == PM_RUN) begin
          s_d.run = 1'b1;
        end
      end
    endcase
  end

  // =====================================================================
  // state register
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      s_q         <= '0;
      s_q.mask    <= MASK_RST;
      s_q.ctrl    <= CTRL_RST;
      s_q.gen     <= 1'b1;
      s_q.pm      <= PM_RUN;
      s_q.vec     <= VEC_RST;
      s_q.run     <= 1'b1;
      s_q.tick    <= 1'b1;
      s_q.waitreq <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign av_readdata_o    = s_q.rdata;
  assign av_waitrequest_o = s_q.waitreq;
  assign stat_o           = s_q.sout;
  assign irq_req_o        = s_q.req;
  assign vector_o         = s_q.vec;
  assign pd_ack_o         = s_q.pdack;
  assign core_run_o       = s_q.run;
  assign core_restart_o   = s_q.rst;
  assign proc_tick_o      = s_q.tick;
  assign flag_out_o       = s_q.ctrl[CTL_FLAGO];

  // =====================================================================
  // checks
  property p_blk;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      mask_wr |=> ##1 !s_q.req;
  endproperty
  a_blk: assert property (p_blk) else $error("irq raised after mask write");

  property p_msk;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      s_q.req && s_q.cur != SRC_PD |-> $past(s_q.mask[s_q.cur]);
  endproperty
  a_msk: assert property (p_msk) else $error("masked source dispatched");

  property p_pdvec;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      s_q.req && s_q.cur == SRC_PD |-> s_q.vec == 16'h002C;
  endproperty
  a_pdvec: assert property (p_pdvec) else $error("wrong power-down vector");

  property p_gen;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      $rose(s_q.req) |-> $past(s_q.gen);
  endproperty
  a_gen: assert property (p_gen) else $error("irq while globally disabled");

  property p_seq;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      $rose(s_q.req) && !$past(s_q.ctrl[CTL_NEST]) |-> $past(s_q.isr) == '0;
  endproperty
  a_seq: assert property (p_seq) else $error("preempted without nesting");

  property p_ack;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      s_q.pdack == (s_q.pm == PM_DORM);
  endproperty
  a_ack: assert property (p_ack) else $error("acknowledge disagrees with state");

  property p_wake;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      $fell(s_q.pdack) && !s_q.ctrl[CTL_OSCOFF] |-> ##[1:WAKE_LIM] s_q.run;
  endproperty
  a_wake: assert property (p_wake) else $error("fast wake too slow");

  property p_stk;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      s_q.depth <= STK_TOP;
  endproperty
  a_stk: assert property (p_stk) else $error("stack depth overrun");

  property p_ovf;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      (int_ack_i || stk_push_i) && s_q.depth == STK_TOP |=> s_q.ovf && s_q.depth == STK_TOP;
  endproperty
  a_ovf: assert property (p_ovf) else $error("stack overflow not flagged");

  property p_slow;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      $rose(s_q.req) && $past(s_q.pm) == PM_IDLE |-> $past(s_q.tick);
  endproperty
  a_slow: assert property (p_slow) else $error("idle wake off the divided tick");

endmodule // dilpc_core

// File: test/dilpc_src_model.sv
// far-side model: external interrupt pins and peripheral request lines
`timescale 1ns/10ps
module dilpc_src_model (
  input  wire logic [6:0]          pin_low_i,
  input  wire logic [5:0]          per_req_i,
  output dilpc_pkg::dilpc_pins_t   pins_o,
  output dilpc_pkg::dilpc_periph_t periph_o
);
  import dilpc_pkg::*;
  // =====
  // pins rest high (pulled up) and go low while a source requests
  assign pins_o   = {~pin_low_i, 1'b0};
  // peripheral lines are raised by the bench no faster than they are served
  assign periph_o = per_req_i;
endmodule // dilpc_src_model

// File: test/tb.sv
// self-checking bench for the interrupt and low-power controller
`timescale 1ns/10ps
module tb;
  import dilpc_pkg::*;
  logic ref_clk_i, reset_n_i, int_ack_i, int_rti_i;
  logic stk_push, stk_pop;
  logic irq_req_o, pd_ack_o, core_run_o, core_restart_o, proc_tick_o, flag_out_o;
  logic av_waitrequest_o;
  logic [31:0] av_readdata_o;
  logic [15:0] stat_i, stat_o, vector_o;
  logic [6:0] pin_low;
  logic [5:0] per_req;
  dilpc_av_req_t av;
  dilpc_pins_t pins;
  dilpc_periph_t periph;
  int n_mismatch, checks, cyc, n;
  logic rst_seen;
  // rows: force bits in [31:16], expected vector in [15:0]
  logic [31:0] rows [12] = '{32'h0001_002C, 32'h0002_0004, 32'h0004_0008, 32'h0008_000C,
    32'h0010_0010, 32'h0020_0014, 32'h0040_0018, 32'h0080_001C, 32'h0100_0020,
    32'h0200_0024, 32'h0400_0028, 32'h0440_0018};

  dilpc_src_model i_src (.pin_low_i(pin_low), .per_req_i(per_req), .pins_o(pins),
    .periph_o(periph));
  dilpc_core #(.WAKE_OSC(400)) i_dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .av_i(av), .av_readdata_o(av_readdata_o), .av_waitrequest_o(av_waitrequest_o),
    .pins_i(pins), .periph_i(periph), .int_ack_i(int_ack_i), .int_rti_i(int_rti_i),
    .stk_push_i(stk_push), .stk_pop_i(stk_pop), .stat_i(stat_i), .stat_o(stat_o),
    .irq_req_o(irq_req_o), .vector_o(vector_o), .pd_ack_o(pd_ack_o),
    .core_run_o(core_run_o), .core_restart_o(core_restart_o),
    .proc_tick_o(proc_tick_o), .flag_out_o(flag_out_o));

  // =====
  // clock, timeout and verdict
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      conclude();
    end
  end

  // =====
  // compare, bus and interrupt tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    av <= '{address: a, read: ~w, write: w, writedata: d, byteenable: 4'hF};
    do begin
      @(posedge ref_clk_i);
    end while (av_waitrequest_o !== 1'b0);
    if (!w) chk(av_readdata_o, d);
    av <= '0;
  endtask
  task automatic grab(input logic [15:0] vec);
    int k;
    k = 0;
    while (irq_req_o !== 1'b1 && k < 60) begin
      @(posedge ref_clk_i);
      k++;
    end
    chk({15'h0, irq_req_o, vector_o}, {16'h1, vec});
    int_ack_i <= 1'b1;
    @(posedge ref_clk_i);
    int_ack_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
  endtask
  task automatic ret();
    int_rti_i <= 1'b1;
    @(posedge ref_clk_i);
    int_rti_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
  endtask
  task automatic take(input logic [15:0] vec);
    grab(vec);
    ret();
  endtask

  // =====
  // main sequence
  initial begin
    reset_n_i = 1'b0;
    av = '0;
    int_ack_i = 1'b0;
    int_rti_i = 1'b0;
    stk_push = 1'b0;
    stk_pop = 1'b0;
    pin_low = '0;
    per_req = '0;
    stat_i = 16'h5A3C;
    repeat (4) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    @(posedge ref_clk_i);
    chk({irq_req_o, pd_ack_o, core_run_o, proc_tick_o}, 4'h3);
    bus(1'b0, OFS_STAT, 32'h0001_0000);
    bus(1'b0, OFS_MASK, 32'h0);
    bus(1'b1, OFS_MASK, 32'h7FE);
    foreach (rows[i]) begin
      bus(1'b1, OFS_FCLR, {16'h0, rows[i][31:16]});
      take(rows[i][15:0]);
    end
    take(16'h0028);
    chk({16'h0, stat_o}, 32'h5A3C);
    bus(1'b1, OFS_MASK, 32'h0);
    bus(1'b1, OFS_FCLR, 32'h400);
    repeat (5) @(posedge ref_clk_i);
    chk(irq_req_o, 1'b0);
    bus(1'b1, OFS_FCLR, 32'h1);
    take(16'h002C);
    bus(1'b1, OFS_FCLR, 32'h0400_0000);
    bus(1'b0, OFS_FCLR, 32'h0);
    bus(1'b0, 5'h14, 32'h0);
    bus(1'b0, OFS_STAT, 32'h0001_0000);
    bus(1'b1, OFS_MASK, 32'h7FE);
    bus(1'b1, OFS_CMD, 32'h2);
    bus(1'b1, OFS_FCLR, 32'h1);
    repeat (5) @(posedge ref_clk_i);
    chk(irq_req_o, 1'b0);
    bus(1'b1, OFS_CMD, 32'h1);
    take(16'h002C);
    pin_low[3] <= 1'b1;
    take(16'h0018);
    pin_low[3] <= 1'b0;
    per_req[0] <= 1'b1;
    take(16'h0028);
    per_req[0] <= 1'b0;
    bus(1'b1, OFS_CTRL, 32'h51);
    @(posedge ref_clk_i);
    chk(flag_out_o, 1'b1);
    pin_low[1] <= 1'b1;
    grab(16'h0020);
    bus(1'b1, OFS_FCLR, 32'h2);
    take(16'h0004);
    pin_low[1] <= 1'b0;
    ret();
    bus(1'b1, OFS_CMD, 32'h24);
    n = 0;
    repeat (64) begin
      @(posedge ref_clk_i);
      n += int'(proc_tick_o);
    end
    chk(n, 4);
    bus(1'b1, OFS_FCLR, 32'h400);
    take(16'h0028);
    bus(1'b1, OFS_CTRL, 32'h20);
    bus(1'b1, OFS_CMD, 32'h40);
    repeat (3) @(posedge ref_clk_i);
    chk({pd_ack_o, core_run_o, proc_tick_o}, 3'b100);
    pin_low[0] <= 1'b1;
    n = 0;
    rst_seen = 1'b0;
    while (core_run_o !== 1'b1 && n < 600) begin
      @(posedge ref_clk_i);
      n++;
      rst_seen |= core_restart_o;
    end
    chk(n > 380 && n < 410, 1'b1);
    repeat (2) @(posedge ref_clk_i);
    chk(rst_seen | core_restart_o, 1'b1);
    pin_low[0] <= 1'b0;
    stk_push <= 1'b1;
    for (int i = 1; i <= 13; i++) begin
      stat_i <= 16'(i);
      @(posedge ref_clk_i);
    end
    stk_push <= 1'b0;
    bus(1'b0, OFS_STAT, 32'h01C1_0000);
    stk_pop <= 1'b1;
    @(posedge ref_clk_i);
    stk_pop <= 1'b0;
    @(posedge ref_clk_i);
    chk({16'h0, stat_o}, 32'hC);
    bus(1'b1, OFS_CMD, 32'h40);
    repeat (3) @(posedge ref_clk_i);
    reset_n_i <= 1'b0;
    @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    @(posedge ref_clk_i);
    chk({pd_ack_o, core_run_o}, 2'b01);
    conclude();
  end
endmodule // tb
